/* File: include/ucsm_pkg.sv */
/*
  Shared constants for the clock-synchronous multi-slave serial channel:
  register offsets, field positions, reset values, counts and states.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package ucsm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_TXBUF  = 8'h00;
  localparam logic [7:0] OFF_RXBUF  = 8'h04;
  localparam logic [7:0] OFF_BAUD   = 8'h08;
  localparam logic [7:0] OFF_MODE   = 8'h0c;
  localparam logic [7:0] OFF_CTRL0  = 8'h10;
  localparam logic [7:0] OFF_CTRL1  = 8'h14;
  localparam logic [7:0] OFF_PHASE  = 8'h18;
  localparam logic [7:0] OFF_SHARED = 8'h1c;

  // channel_mode_register fields
  localparam int MODE_SMD   = 0;
  localparam int MODE_CLOCK_SOURCE_SELECT = 3;
  localparam int MODE_DATA_POLARITY_INVERT = 7;
  localparam logic [2:0] MODE_SYNC_MULTI = 3'h1;

  // channel_control_zero fields
  localparam int C0_CLK   = 0;
  localparam int C0_CRS   = 2;
  localparam int C0_SHIFT_REGISTER_EMPTY_FLAG = 3;
  localparam int C0_CRD   = 4;
  localparam int C0_NCH   = 5;
  localparam int C0_CLOCK_EDGE_POLARITY = 6;
  localparam int C0_BIT_ORDER_SELECT = 7;

  // channel_control_one fields
  localparam int C1_TE = 0;
  localparam int C1_TI = 1;
  localparam int C1_RE = 2;
  localparam int C1_RI = 3;
  localparam logic [7:0] C1_STORE_MASK = 8'h35;

  // receive_buffer view and phase register fields
  localparam int RX_OER   = 12;
  localparam int PH_CLOCK_PHASE_SELECT  = 1;
  localparam int PH_CLOCK_OUTPUT_DRIVE  = 3;

  // shared_serial_control fields
  localparam int SH_IRS0   = 0;
  localparam int SH_IRS1   = 1;
  localparam int SH_RRM0   = 2;
  localparam int SH_RRM1   = 3;
  localparam int SH_CLOCK_PIN_SELECT = 4;
  localparam int SH_MULTI_CLOCK_PIN_ENABLE = 5;

  // Reset values
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;

  // Frame and prescaler counts
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] OVR_BIT   = 4'h7;
  localparam logic [4:0] PRE_F2    = 5'h01;
  localparam logic [4:0] PRE_F8    = 5'h07;
  localparam logic [4:0] PRE_F32   = 5'h1f;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01
  } ucsm_state_e;

endpackage

/* File: test/testbench.sv */
/*
  Testbench for the serial channel in master and slave mode.
  Assumes the peer model on the pins and a bound port checker.
*/
`timescale 1ns/1ps

module testbench;
  logic        sys_clk, arst_n, psel, penable, pwrite, load, rerr;
  logic [7:0]  paddr, peer_byte, peer_rx;
  logic [31:0] pwdata, prdata, rq;
  logic        pready, pslverr, sclk_out, sclk_oe_n, txd_out, txd_oe_n;
  logic        tx_req, rx_req, miso;
  logic [3:0]  peer_n;
  int          num_errors, checks, t_tx, t_rx, hp;
  logic        ext_sclk;
  wire         clk_line = sclk_oe_n ? ext_sclk : sclk_out;

  // Shared clock line: channel drives it as master, bench as slave
  ucsm_serial_channel #(.CHAN(0), .ADDR_W(8)) uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_in(clk_line), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n), .rxd_in(miso), .tx_req(tx_req), .rx_req(rx_req)
  );
  ucsm_spi_peer peer (
    .sclk(clk_line), .mosi(txd_out), .miso(miso), .load(load),
    .tx_byte(peer_byte), .rx_byte(peer_rx), .nbits(peer_n)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1) @(posedge sys_clk);
    rq = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic watch();
    int   last, tail;
    logic prev;
    t_tx = -1;
    t_rx = -1;
    hp = 0;
    last = -1;
    tail = 0;
    prev = sclk_out;
    for (int i = 0; i < 600 && tail < 8; i++) begin
      @(negedge sys_clk);
      if (tx_req === 1'h1 && t_tx < 0) t_tx = i;
      if (rx_req === 1'h1) t_rx = i;
      if (sclk_out !== prev) begin
        if (last >= 0 && hp == 0) hp = i - last;
        last = i;
      end
      prev = sclk_out;
      if (peer_n == 4'h8) tail++;
    end
  endtask

  task automatic frame(input logic [7:0] d, input logic [7:0] pb);
    peer_byte <= pb;
    load <= 1'h1;
    @(posedge sys_clk);
    load <= 1'h0;
    apb(1'h1, ucsm_pkg::OFF_TXBUF, {24'h0, d});
    watch();
  endtask

  task automatic t_reset();
    apb(1'h0, ucsm_pkg::OFF_CTRL0, 32'h0);
    chk(rq, 32'h18);
    apb(1'h0, ucsm_pkg::OFF_CTRL1, 32'h0);
    chk(rq, 32'h02);
    apb(1'h0, 8'h24, 32'h0);
    chk({rq[30:0], rerr}, 32'h1);
  endtask

  task automatic t_master();
    apb(1'h1, ucsm_pkg::OFF_MODE, 32'h01);
    apb(1'h1, ucsm_pkg::OFF_BAUD, 32'h03);
    apb(1'h1, ucsm_pkg::OFF_CTRL0, 32'h10);
    apb(1'h1, ucsm_pkg::OFF_CTRL1, 32'h05);
    chk(32'(sclk_oe_n), 32'h0);
    frame(8'ha5, 8'h3c);
    chk(32'(peer_rx), 32'ha5);
    chk(32'(peer_n), 32'h8);
    chk(32'(hp), 32'h4);
    chk(32'(t_tx >= 0 && t_tx < hp), 32'h1);
    chk(32'(t_rx >= 0), 32'h1);
    apb(1'h0, ucsm_pkg::OFF_CTRL0, 32'h0);
    chk(rq, 32'h18);
    apb(1'h0, ucsm_pkg::OFF_CTRL1, 32'h0);
    chk(rq, 32'h0f);
    apb(1'h0, ucsm_pkg::OFF_RXBUF, 32'h0);
    chk(rq, 32'h3c);
    apb(1'h0, ucsm_pkg::OFF_CTRL1, 32'h0);
    chk(rq, 32'h07);
  endtask

  task automatic t_overrun();
    frame(8'h22, 8'h11);
    apb(1'h1, ucsm_pkg::OFF_CTRL0, 32'h11);
    apb(1'h1, ucsm_pkg::OFF_SHARED, 32'h01);
    frame(8'h33, 8'h99);
    chk(32'(t_rx), 32'hffffffff);
    chk(32'(hp), 32'h8);
    chk(32'(t_tx > 8 * hp), 32'h1);
    apb(1'h0, ucsm_pkg::OFF_CTRL1, 32'h0);
    chk(rq, 32'h0f);
    apb(1'h0, ucsm_pkg::OFF_RXBUF, 32'h0);
    chk(32'(rq[12]), 32'h1);
  endtask

  task automatic t_enable();
    apb(1'h1, ucsm_pkg::OFF_CTRL1, 32'h00);
    frame(8'h55, 8'h0f);
    chk(32'(peer_n), 32'h0);
    apb(1'h1, ucsm_pkg::OFF_CTRL1, 32'h01);
    watch();
    chk(32'(peer_rx), 32'h55);
    chk(32'(t_rx), 32'hffffffff);
  endtask

  task automatic t_pins();
    apb(1'h1, ucsm_pkg::OFF_CTRL0, 32'h30);
    repeat (4) @(negedge sys_clk);
    chk(32'(txd_oe_n), 32'h1);
    apb(1'h1, ucsm_pkg::OFF_CTRL0, 32'h10);
    repeat (4) @(negedge sys_clk);
    chk(32'(txd_oe_n), 32'h0);
    for (int k = 0; k < 4; k++) begin
      apb(1'h1, ucsm_pkg::OFF_CTRL0, {25'h0, k[0], 6'h10});
      apb(1'h1, ucsm_pkg::OFF_PHASE, {30'h0, k[1], 1'h0});
      repeat (4) @(negedge sys_clk);
      chk(32'(sclk_out), 32'(!(k[0] ^ k[1])));
    end
    apb(1'h1, ucsm_pkg::OFF_MODE, 32'h09);
    repeat (4) @(negedge sys_clk);
    chk(32'(sclk_oe_n), 32'h1);
  endtask

  task automatic t_slave();
    apb(1'h1, ucsm_pkg::OFF_CTRL0, 32'h10);
    apb(1'h1, ucsm_pkg::OFF_PHASE, 32'h00);
    apb(1'h1, ucsm_pkg::OFF_CTRL1, 32'h05);
    fork
      frame(8'h5a, 8'hc3);
      begin
        repeat (10) @(posedge sys_clk);
        repeat (16) begin
          ext_sclk <= ~ext_sclk;
          repeat (6) @(posedge sys_clk);
        end
      end
    join
    chk(32'(peer_rx), 32'h5a);
    chk(32'(peer_n), 32'h8);
    chk(32'(t_rx > 0), 32'h1);
    chk(32'(t_tx), 32'(t_rx));
    apb(1'h0, ucsm_pkg::OFF_RXBUF, 32'h0);
    chk(rq, 32'hc3);
  endtask

  task automatic summarize();
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    arst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    load = 1'h0;
    ext_sclk = 1'h1;
    peer_byte = 8'h00;
    num_errors = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'h1;
    t_reset();
    t_master();
    t_overrun();
    t_enable();
    t_pins();
    t_slave();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end
endmodule

/* File: test/ucsm_sc_asserts.sv */
/*
  Port checker for the serial channel.
  Assumes it is bound to ucsm_serial_channel.
*/
`timescale 1ns/1ps

module ucsm_sc_asserts #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              arst_n,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Serial side
  input wire logic              sclk_out,
  input wire logic              sclk_oe_n,
  input wire logic              tx_req,
  input wire logic              rx_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  wire        rd_setup = psel && !penable && !pwrite;
  logic [4:0] rise_ff;

  // Rising transfer clock edges since last receive pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) rise_ff <= 5'h00;
    else if (rx_req || sclk_oe_n) rise_ff <= 5'h00;
    else if ($rose(sclk_out)) rise_ff <= rise_ff + 5'h01;
  end

  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  property p_err_map; psel && penable && paddr[7:5] != 3'h0 |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("no pslverr on unmapped");
  property p_crd; rd_setup && paddr == ucsm_pkg::OFF_CTRL0 |=> prdata[4]; endproperty
  a_crd: assert property (p_crd) else $error("handshake disable reads 0");
  property p_rx_upper;
    rd_setup && paddr == ucsm_pkg::OFF_RXBUF |=> prdata[11:8] == 4'h0;
  endproperty
  a_rx_upper: assert property (p_rx_upper) else $error("receive data wider than 8");
  property p_tx_pulse; tx_req |=> !tx_req; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx_req longer than 1");
  property p_rx_pulse; rx_req |=> !rx_req; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx_req longer than 1");
  property p_eight;
    rx_req && !sclk_oe_n |-> rise_ff == 5'h08 || (rise_ff == 5'h07 && $rose(sclk_out));
  endproperty
  a_eight: assert property (p_eight) else $error("frame not eight clocks");
  property p_reset; $rose(arst_n) |-> sclk_oe_n && !tx_req && !rx_req && pready; endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
endmodule

bind ucsm_serial_channel ucsm_sc_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .tx_req(tx_req), .rx_req(rx_req)
);

/* File: test/ucsm_spi_peer.sv */
/*
  Serial peer on the transfer pins.
  Assumes polarity 0, phase 0: sample rising, shift falling, LSB first.
*/
`timescale 1ns/1ps

module ucsm_spi_peer (
  // Transfer pins
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  // Bench side
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic      [3:0] nbits
);
  logic [7:0] sr;

  always @(posedge load) begin
    sr = tx_byte;
    nbits = 4'h0;
    miso = tx_byte[0];
  end
  // Same polarity and phase as the channel
  always @(posedge sclk) begin
    if (nbits < 4'h8) begin
      rx_byte = {mosi, rx_byte[7:1]};
      nbits = nbits + 4'h1;
    end
  end
  always @(negedge sclk) begin
    if (nbits != 4'h0 && nbits < 4'h8) begin
      sr = sr >> 1;
      miso = sr[0];
    end
  end
endmodule

/* File: verilog/ucsm_baud_gen.sv */
/*
  Transfer clock generator: prescaler and 8-bit divider giving one
  pulse per half period of the master transfer clock.
  Assumes run is held high for the whole transfer.
*/
`timescale 1ns/1ps

module ucsm_baud_gen (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] src_sel,
  input  wire logic [7:0] divisor,
  // Half-period pulse
  output logic            half_tick
);

  logic [4:0] pre_ff;
  logic [7:0] div_ff;
  logic       tick_ff;
  logic       src_tick;
  logic       div_end;
  logic [4:0] nxt_pre;
  logic [7:0] nxt_div;

  // Count source select: f1, f2, f8, f32
  assign src_tick = (src_sel == 2'h0) ? 1'b1 :
                    (src_sel == 2'h1) ? (pre_ff[0] == ucsm_pkg::PRE_F2[0]) :
                    (src_sel == 2'h2) ? (pre_ff[2:0] == ucsm_pkg::PRE_F8[2:0]) :
                    (pre_ff == ucsm_pkg::PRE_F32);
  assign div_end  = src_tick && (div_ff == divisor);
  assign nxt_pre  = pre_ff + 5'h01;
  assign nxt_div  = !run ? 8'h00 : div_end ? 8'h00 : src_tick ? div_ff + 8'h01 : div_ff;
  assign half_tick = tick_ff;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff  <= 5'h00;
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      pre_ff  <= nxt_pre;
      div_ff  <= nxt_div;
      tick_ff <= run && div_end;
    end
  end

endmodule

/* File: verilog/ucsm_serial_channel.sv */
/*
  One serial channel in clock-synchronous multi-slave mode with its
  APB register file, master clock generation and slave clock input.
  Assumes slave select is done by general ports outside this block.
*/
// The APB register port and the address map were left to the implementer.
// Notes on behaviour
// - Overrun leaves receive buffer undefined and raises no receive request.
// - Received eight bits are readable in receive buffer bits 0 to 7.
// - Clock source select 0 is master on divider, 1 is slave.
// - Two-bit count source field picks the prescaled clock for the divider.
// - Handshake disable reads 1; handshake select has no effect.
// - A flag shows that the transmit shift register is empty.
// - A control bit picks push-pull or open-drain transmit output.
// - Phase and polarity bits select one of four clock schemes.
// - Transmission only when the transmit enable bit is 1.
// - Reception only when the receive enable bit is 1.
// - A flag shows whether the transmit buffer is empty or full.
// - A flag shows completed reception with data in the buffer.
// - Shared register holds a transmit request cause bit per channel.
// - With multi-pin clock bit 0 the clock pin select has no effect.
// - Master and slaves use the same clock polarity and phase.
// - Every transfer moves exactly eight data bits.
// - Master clock is source clock over twice divider plus one.
// - Overrun when unread buffer meets the seventh bit of new data.
// - Transfer needs transmit enable and a full transmit buffer.
`timescale 1ns/1ps

module ucsm_serial_channel #(
  parameter int CHAN   = 0,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Serial pins
  input  wire logic              sclk_in,
  output logic                   sclk_out,
  output logic                   sclk_oe_n,
  output logic                   txd_out,
  output logic                   txd_oe_n,
  input  wire logic              rxd_in,
  // Transfer event pulses
  output logic                   tx_req,
  output logic                   rx_req
);

  localparam int IRS_BIT = (CHAN == 1) ? ucsm_pkg::SH_IRS1 : ucsm_pkg::SH_IRS0;

  // Registers
  logic [7:0]  tb_ff;
  logic [7:0]  rb_ff;
  logic [7:0]  baud_ff;
  logic [7:0]  mode_ff;
  logic [7:0]  ctrl0_ff;
  logic [7:0]  ctrl1_ff;
  logic [7:0]  phase_ff;
  logic [7:0]  shared_ff;
  logic        tx_full_ff;
  logic        shift_register_empty_flag_ff;
  logic        ri_ff;
  logic        oer_ff;
  logic [31:0] prdata_ff;
  logic [1:0]  sync1_ff;
  logic [1:0]  sync2_ff;
  logic        sclk_d_ff;
  logic        sclk_ff;
  logic        txd_ff;
  logic        txoe_n_ff;
  logic        sclkoe_n_ff;
  logic        tx_req_ff;
  logic        rx_req_ff;
  logic        rx_on_ff;
  logic        frame_ovr_ff;
  logic [7:0]  tx_sh_ff;
  logic [7:0]  rx_sh_ff;
  logic [3:0]  bit_cnt_ff;
  ucsm_pkg::ucsm_state_e st_ff, nxt_st;

  // Bus decode
  wire setup   = psel && !penable;
  wire access  = psel && penable;
  wire wr      = access && pwrite;
  wire rd      = access && !pwrite;
  wire hit_tb  = paddr == ADDR_W'(ucsm_pkg::OFF_TXBUF);
  wire hit_rb  = paddr == ADDR_W'(ucsm_pkg::OFF_RXBUF);
  wire hit_bd  = paddr == ADDR_W'(ucsm_pkg::OFF_BAUD);
  wire hit_md  = paddr == ADDR_W'(ucsm_pkg::OFF_MODE);
  wire hit_c0  = paddr == ADDR_W'(ucsm_pkg::OFF_CTRL0);
  wire hit_c1  = paddr == ADDR_W'(ucsm_pkg::OFF_CTRL1);
  wire hit_ph  = paddr == ADDR_W'(ucsm_pkg::OFF_PHASE);
  wire hit_sh  = paddr == ADDR_W'(ucsm_pkg::OFF_SHARED);
  wire mapped  = hit_tb || hit_rb || hit_bd || hit_md || hit_c0 || hit_c1 || hit_ph || hit_sh;
  wire wr_tb   = wr && hit_tb;
  wire rd_rb   = rd && hit_rb;

  // Mode fields
  wire active  = mode_ff[2:0] == ucsm_pkg::MODE_SYNC_MULTI;
  wire slave   = mode_ff[ucsm_pkg::MODE_CLOCK_SOURCE_SELECT];
  wire invert  = mode_ff[ucsm_pkg::MODE_DATA_POLARITY_INVERT];
  wire clock_edge_polarity   = ctrl0_ff[ucsm_pkg::C0_CLOCK_EDGE_POLARITY];
  wire clock_phase_select    = phase_ff[ucsm_pkg::PH_CLOCK_PHASE_SELECT];
  wire lsb_1st = !ctrl0_ff[ucsm_pkg::C0_BIT_ORDER_SELECT];
  wire odrain  = ctrl0_ff[ucsm_pkg::C0_NCH];
  wire te      = ctrl1_ff[ucsm_pkg::C1_TE];
  wire re      = ctrl1_ff[ucsm_pkg::C1_RE];
  wire irs     = shared_ff[IRS_BIT];

  // Clock edges: master from own divider, slave from synchronised pin
  wire half_tick;
  wire xfer     = st_ff == ucsm_pkg::ST_XFER;
  wire idle_lvl = !(clock_edge_polarity ^ clock_phase_select);
  wire s_rise   = sync2_ff[0] && !sclk_d_ff;
  wire s_fall   = !sync2_ff[0] && sclk_d_ff;
  wire m_rise   = half_tick && !sclk_ff;
  wire m_fall   = half_tick && sclk_ff;
  wire rise     = xfer && (slave ? s_rise : m_rise);
  wire fall     = xfer && (slave ? s_fall : m_fall);
  wire smp_edge = clock_edge_polarity ? fall : rise;
  wire out_edge = clock_edge_polarity ? rise : fall;
  wire rx_bit   = sync2_ff[1] ^ invert;
  wire last_smp = smp_edge && (bit_cnt_ff == ucsm_pkg::DATA_BITS - 4'h1);
  wire ovr_hit  = smp_edge && rx_on_ff && ri_ff
                  && (bit_cnt_ff == ucsm_pkg::OVR_BIT - 4'h1);
  wire start    = !xfer && active && te && tx_full_ff;
  wire done     = xfer && last_smp;
  wire rx_store = done && rx_on_ff && !frame_ovr_ff && !ovr_hit;
  wire shift_en = out_edge && (bit_cnt_ff != 4'h0) && !last_smp;

  // Shift data paths
  wire [7:0] rx_next = lsb_1st ? {rx_bit, rx_sh_ff[7:1]} : {rx_sh_ff[6:0], rx_bit};
  wire [7:0] tx_next = lsb_1st ? {1'b0, tx_sh_ff[7:1]} : {tx_sh_ff[6:0], 1'b0};
  logic [7:0] nxt_tx_sh;
  logic       cur_bit;

  always_comb begin
    nxt_st    = st_ff;
    nxt_tx_sh = tx_sh_ff;
    if (start) begin
      nxt_st    = ucsm_pkg::ST_XFER;
      nxt_tx_sh = tb_ff;
    end else if (done || (xfer && !active)) begin
      nxt_st = ucsm_pkg::ST_IDLE;
    end else if (shift_en) begin
      nxt_tx_sh = tx_next;
    end
    cur_bit = lsb_1st ? nxt_tx_sh[0] : nxt_tx_sh[7];
  end

  // Register read views
  logic [7:0]  c0_view, c1_view;
  logic [31:0] rb_view, rd_mux;

  always_comb begin
    c0_view = ctrl0_ff;
    c0_view[ucsm_pkg::C0_SHIFT_REGISTER_EMPTY_FLAG] = shift_register_empty_flag_ff;
    c0_view[ucsm_pkg::C0_CRD]   = 1'b1;
    c1_view = ctrl1_ff & ucsm_pkg::C1_STORE_MASK;
    c1_view[ucsm_pkg::C1_TI] = !tx_full_ff;
    c1_view[ucsm_pkg::C1_RI] = ri_ff;
    rb_view = {24'h000000, rb_ff};
    rb_view[ucsm_pkg::RX_OER] = oer_ff;
    rd_mux = 32'h00000000;
    if (hit_tb) begin
      rd_mux = {24'h000000, tb_ff};
    end else if (hit_rb) begin
      rd_mux = rb_view;
    end else if (hit_bd) begin
      rd_mux = {24'h000000, baud_ff};
    end else if (hit_md) begin
      rd_mux = {24'h000000, mode_ff};
    end else if (hit_c0) begin
      rd_mux = {24'h000000, c0_view};
    end else if (hit_c1) begin
      rd_mux = {24'h000000, c1_view};
    end else if (hit_ph) begin
      rd_mux = {24'h000000, phase_ff};
    end else if (hit_sh) begin
      rd_mux = {24'h000000, shared_ff};
    end
  end

  // Flag next values; hardware set wins over software clear
  wire nxt_tx_full = wr_tb ? 1'b1 : (start ? 1'b0 : tx_full_ff);
  wire nxt_ri      = rx_store ? 1'b1 : (rd_rb ? 1'b0 : ri_ff);
  wire nxt_oer     = ovr_hit ? 1'b1 : ((!re || !active) ? 1'b0 : oer_ff);
  wire nxt_shift_register_empty_flag   = start ? 1'b0 : (done || (xfer && !active)) ? 1'b1 : shift_register_empty_flag_ff;
  wire nxt_sclk    = (xfer && !slave && half_tick) ? !sclk_ff : (xfer ? sclk_ff : idle_lvl);
  wire nxt_txd     = (xfer || start) ? (cur_bit ^ invert) : 1'b1;
  wire nxt_txoe_n  = !(active && te) ? 1'b1 : (odrain ? nxt_txd : 1'b0);
  wire nxt_tx_req  = (start && !irs) || (done && irs);
  wire nxt_cnt_inc = smp_edge && !last_smp;

  ucsm_baud_gen u_baud (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .run       (xfer && !slave),
    .src_sel   (ctrl0_ff[1:0]),
    .divisor   (baud_ff),
    .half_tick (half_tick)
  );

  // Pin synchronisers and edge history
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff  <= 2'h3;
      sync2_ff  <= 2'h3;
      sclk_d_ff <= 1'b1;
    end else begin
      sync1_ff  <= {rxd_in, sclk_in};
      sync2_ff  <= sync1_ff;
      sclk_d_ff <= sync2_ff[0];
    end
  end

  // Software registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tb_ff     <= ucsm_pkg::RST_REG;
      baud_ff   <= ucsm_pkg::RST_BAUD;
      mode_ff   <= ucsm_pkg::RST_REG;
      ctrl0_ff  <= ucsm_pkg::RST_REG;
      ctrl1_ff  <= ucsm_pkg::RST_REG;
      phase_ff  <= ucsm_pkg::RST_REG;
      shared_ff <= ucsm_pkg::RST_REG;
      prdata_ff <= 32'h00000000;
    end else begin
      if (wr_tb) tb_ff <= pwdata[7:0];
      if (wr && hit_bd) baud_ff <= pwdata[7:0];
      if (wr && hit_md) mode_ff <= pwdata[7:0];
      if (wr && hit_c0) ctrl0_ff <= pwdata[7:0];
      if (wr && hit_c1) ctrl1_ff <= pwdata[7:0] & ucsm_pkg::C1_STORE_MASK;
      if (wr && hit_ph) phase_ff <= pwdata[7:0];
      if (wr && hit_sh) shared_ff <= pwdata[7:0];
      if (setup) prdata_ff <= rd_mux;
    end
  end

  // Transfer engine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff        <= ucsm_pkg::ST_IDLE;
      tx_sh_ff     <= 8'h00;
      rx_sh_ff     <= 8'h00;
      rb_ff        <= 8'h00;
      bit_cnt_ff   <= 4'h0;
      tx_full_ff   <= 1'b0;
      shift_register_empty_flag_ff     <= 1'b1;
      ri_ff        <= 1'b0;
      oer_ff       <= 1'b0;
      rx_on_ff     <= 1'b0;
      frame_ovr_ff <= 1'b0;
      sclk_ff      <= 1'b1;
      sclkoe_n_ff  <= 1'b1;
      txd_ff       <= 1'b1;
      txoe_n_ff    <= 1'b1;
      tx_req_ff    <= 1'b0;
      rx_req_ff    <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      tx_sh_ff     <= nxt_tx_sh;
      tx_full_ff   <= nxt_tx_full;
      shift_register_empty_flag_ff     <= nxt_shift_register_empty_flag;
      ri_ff        <= nxt_ri;
      oer_ff       <= nxt_oer;
      sclk_ff      <= nxt_sclk;
      sclkoe_n_ff  <= !(active && !slave);
      txd_ff       <= nxt_txd;
      txoe_n_ff    <= nxt_txoe_n;
      tx_req_ff    <= nxt_tx_req;
      rx_req_ff    <= rx_store;
      if (smp_edge) rx_sh_ff <= rx_next;
      if (rx_store) rb_ff <= rx_next;
      if (start) begin
        bit_cnt_ff   <= 4'h0;
        rx_on_ff     <= re;
        frame_ovr_ff <= 1'b0;
      end else begin
        if (nxt_cnt_inc) bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (ovr_hit) frame_ovr_ff <= 1'b1;
      end
    end
  end

  // Outputs
  assign prdata    = prdata_ff;
  assign pready    = 1'b1;
  assign pslverr   = access && !mapped;
  assign sclk_out  = sclk_ff;
  assign sclk_oe_n = sclkoe_n_ff;
  assign txd_out   = txd_ff;
  assign txd_oe_n  = txoe_n_ff;
  assign tx_req    = tx_req_ff;
  assign rx_req    = rx_req_ff;

endmodule
